// ===== emb_map.svh
`ifndef EMB_MAP_SVH
`define EMB_MAP_SVH

// ----------------------------------------------------------------------
// access sizes and kinds
// ----------------------------------------------------------------------
`define EMB_SIZE_BYTE 2'h0
`define EMB_SIZE_HALF 2'h1
`define EMB_SIZE_WORD 2'h2
`define EMB_KIND_READ 2'h0
`define EMB_KIND_WRITE 2'h1
`define EMB_KIND_FETCH 2'h2

// ----------------------------------------------------------------------
// abort vectors
// ----------------------------------------------------------------------
`define EMB_VEC_PREFETCH 32'h0000000C
`define EMB_VEC_DATA 32'h00000010

// ----------------------------------------------------------------------
// page size codes and base compare masks over address bits 31..20
// ----------------------------------------------------------------------
`define EMB_PAGE_1M 2'h0
`define EMB_PAGE_4M 2'h1
`define EMB_PAGE_16M 2'h2
`define EMB_PAGE_64M 2'h3
`define EMB_MASK_1M 12'hFFF
`define EMB_MASK_4M 12'hFFC
`define EMB_MASK_16M 12'hFF0
`define EMB_MASK_64M 12'hFC0

`endif

// ===== emb_pkg.sv
package emb_pkg;

  typedef logic [1:0] emb_size_t;
  typedef logic [1:0] emb_kind_t;

  typedef enum logic {
    EMB_IDLE,
    EMB_ACCESS
  } emb_phase_e;

  typedef struct packed {
    emb_phase_e st;
    logic [7:0] cs_hit;
    logic [31:0] addr;
    emb_size_t size;
    emb_kind_t kind;
    logic [31:0] wdata;
    logic from_periph;
    logic [1:0] beat;
    logic [1:0] last_beat;
    logic bus16;
    logic bytesel;
    logic [31:0] rdata;
    logic rsp_done;
    logic rsp_periph;
    logic abort_pulse;
    logic abort_fetch;
    logic [31:0] abort_vector;
    logic [31:0] aar;
    logic undef;
    logic misal;
    emb_size_t asize;
    emb_kind_t atype;
    logic [23:0] hold;
    logic [23:0] pin_addr;
    logic [7:0] pin_cs;
    logic rd;
    logic wr0;
    logic wr1;
    logic [15:0] d_out;
    logic d_oe;
  } emb_state_s;

endpackage

// ===== emb_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - serve access requests from both the core and the peripheral data controller
// - eight chip-selects and a 24-bit external address covering 16M bytes
// - 16-bit data bus usable with 8-bit or 16-bit devices
// - separate read and write strobes for glue-free connection
// - each beat of an access with no wait completes in one clock cycle
// - base address and page size pick the chip-select for an address
// - 8-bit devices use address bits 0..23, 16-bit devices bits 1..23
// - smaller devices repeat across their page; in-page accesses complete unless misaligned or refused by the privileged-only check
// - out-of-page access aborts: prefetch vector for fetches, data vector else
// - overlapping windows assert all matches; lowest index governs the access
// - abort address captured on every abort, latest only, zero after reset
// - abort status holds undefined, misaligned, access size and access type
// - between external accesses hold address, float data, strobes inactive
// - chip-selects 0..3 active low, chip-selects 4..7 active high
// - address bits 23..20 share pins with chip-selects 4..7
// - A0 doubles as lower select; strobes double as enables by mode
// - privileged-only check applies only with protection mode input set
// - a count field turns pins 23 downward into chip-selects 4 to 7
// - each chip-select has its own 8 or 16 bit width
// - byte-write mode: A0 unused, two write strobes, one read strobe
`include "emb_map.svh"

module emb_ctrl #(
  parameter int CS_COUNT = 8
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic core_req_valid,
  output logic core_req_ready,
  input wire logic [31:0] core_req_addr,
  input wire emb_pkg::emb_size_t core_req_size,
  input wire emb_pkg::emb_kind_t core_req_kind,
  input wire logic [31:0] core_req_wdata,
  input wire logic core_req_privileged,
  input wire logic periph_req_valid,
  output logic periph_req_ready,
  input wire logic [31:0] periph_req_addr,
  input wire emb_pkg::emb_size_t periph_req_size,
  input wire logic periph_req_write,
  input wire logic [31:0] periph_req_wdata,
  output logic rsp_done,
  output logic rsp_to_periph,
  output logic [31:0] rsp_rdata,
  output logic busy,
  output logic abort_valid,
  output logic abort_fetch,
  output logic [31:0] abort_vector,
  output logic [31:0] abort_address_register,
  output logic abort_undefined,
  output logic abort_misaligned,
  output emb_pkg::emb_size_t abort_size,
  output emb_pkg::emb_kind_t abort_type,
  input wire logic [8*12-1:0] cs_base,
  input wire logic [15:0] cs_page_size,
  input wire logic [7:0] cs_enable,
  input wire logic [7:0] bus_width_select,
  input wire logic [7:0] byte_access_type,
  input wire logic [7:0] cs_privileged_only,
  input wire logic [2:0] chip_select_count,
  input wire logic protection_mode_input,
  input wire logic wait_request_n,
  output logic [23:0] ext_addr_pins,
  output logic [3:0] low_chip_select_lines,
  output logic read_strobe_n,
  output logic lower_write_strobe_n,
  output logic upper_write_strobe_n,
  output logic [15:0] data_out,
  output logic data_oe,
  input wire logic [15:0] data_in
);
  import emb_pkg::*;

  emb_state_s s;
  emb_state_s n;

  logic sel_periph;
  logic sel_valid;
  logic [31:0] sel_addr;
  emb_size_t sel_size;
  emb_kind_t sel_kind;
  logic [31:0] sel_wdata;
  logic sel_priv;
  logic [7:0] sel_hits;
  logic [2:0] gov;
  logic [11:0] mask;

  // ----------------------------------------------------------------------
  // request selection
  // ----------------------------------------------------------------------
  // the peripheral channel wins ties: it streams, a stall costs it more
  assign sel_periph = periph_req_valid;
  assign sel_valid = periph_req_valid | core_req_valid;
  assign sel_addr = sel_periph ? periph_req_addr : core_req_addr;
  assign sel_size = sel_periph ? periph_req_size : core_req_size;
  assign sel_kind = !sel_periph ? core_req_kind :
    (periph_req_write ? `EMB_KIND_WRITE : `EMB_KIND_READ);
  assign sel_wdata = sel_periph ? periph_req_wdata : core_req_wdata;
  assign sel_priv = sel_periph | core_req_privileged;
  assign periph_req_ready = (s.st == EMB_IDLE);
  assign core_req_ready = (s.st == EMB_IDLE) && !periph_req_valid;

  // ----------------------------------------------------------------------
  // window decode
  // ----------------------------------------------------------------------
  always_comb begin
    sel_hits = 8'h00;
    gov = 3'h0;
    mask = `EMB_MASK_1M;
    for (int i = 0; i < CS_COUNT; i++) begin
      case (cs_page_size[2*i +: 2])
        `EMB_PAGE_4M: mask = `EMB_MASK_4M;
        `EMB_PAGE_16M: mask = `EMB_MASK_16M;
        `EMB_PAGE_64M: mask = `EMB_MASK_64M;
        default: mask = `EMB_MASK_1M;
      endcase
      // only the page-sized upper bits compare, so a small part repeats
      sel_hits[i] = cs_enable[i] &&
        ((sel_addr[31:20] & mask) == (cs_base[12*i +: 12] & mask));
    end
    for (int i = CS_COUNT - 1; i >= 0; i--) begin
      if (sel_hits[i]) begin
        gov = 3'(i);
      end
    end
  end

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    logic misal;
    logic undef;
    logic privfail;
    logic [2:0] off;
    logic [23:0] ba;
    logic lo;
    logic hi;
    logic [31:0] chunk;
    misal = 1'b0;
    undef = 1'b0;
    privfail = 1'b0;
    off = 3'h0;
    ba = 24'h000000;
    lo = 1'b0;
    hi = 1'b0;
    chunk = 32'h00000000;
    n = s;
    n.rsp_done = 1'b0;
    n.abort_pulse = 1'b0;
    if (s.st == EMB_IDLE && sel_valid) begin
      misal = (sel_size == `EMB_SIZE_HALF && sel_addr[0]) ||
              (sel_size == `EMB_SIZE_WORD && sel_addr[1:0] != 2'h0);
      undef = (sel_hits == 8'h00);
      privfail = protection_mode_input && !sel_priv && !undef &&
                 cs_privileged_only[gov];
      if (undef || misal || privfail) begin
        // no transition to access: pins stay quiet for this request
        n.abort_pulse = 1'b1;
        n.abort_fetch = (sel_kind == `EMB_KIND_FETCH);
        n.abort_vector = (sel_kind == `EMB_KIND_FETCH) ? `EMB_VEC_PREFETCH :
                                                          `EMB_VEC_DATA;
        n.aar = sel_addr;
        n.undef = undef;
        n.misal = misal;
        n.asize = sel_size;
        n.atype = sel_kind;
      end else begin
        n.st = EMB_ACCESS;
        n.cs_hit = sel_hits;
        n.addr = sel_addr;
        n.size = sel_size;
        n.kind = sel_kind;
        n.wdata = sel_wdata;
        n.from_periph = sel_periph;
        n.beat = 2'h0;
        n.bus16 = bus_width_select[gov];
        n.bytesel = byte_access_type[gov];
        n.rdata = 32'h00000000;
        if (bus_width_select[gov]) begin
          n.last_beat = (sel_size == `EMB_SIZE_WORD) ? 2'h1 : 2'h0;
        end else begin
          n.last_beat = (sel_size == `EMB_SIZE_WORD) ? 2'h3 :
                        (sel_size == `EMB_SIZE_HALF) ? 2'h1 : 2'h0;
        end
      end
    end else if (s.st == EMB_ACCESS && wait_request_n) begin
      if (s.kind != `EMB_KIND_WRITE) begin
        if (!s.bus16) begin
          n.rdata = s.rdata | ({24'h000000, data_in[7:0]} << {s.beat, 3'h0});
        end else if (s.size == `EMB_SIZE_BYTE) begin
          n.rdata = {24'h000000, s.addr[0] ? data_in[15:8] : data_in[7:0]};
        end else begin
          n.rdata = s.rdata | ({16'h0000, data_in} << {s.beat, 4'h0});
        end
      end
      if (s.beat == s.last_beat) begin
        n.st = EMB_IDLE;
        n.rsp_done = 1'b1;
        n.rsp_periph = s.from_periph;
      end else begin
        n.beat = s.beat + 2'h1;
      end
    end

    // pins follow the next state so every pin comes straight from a flop
    if (n.st == EMB_ACCESS) begin
      off = n.bus16 ? {n.beat, 1'b0} : {1'b0, n.beat};
      ba = n.addr[23:0] + {21'h000000, off};
      lo = !n.bus16 || n.size != `EMB_SIZE_BYTE || !ba[0];
      hi = n.bus16 && (n.size != `EMB_SIZE_BYTE || ba[0]);
      chunk = n.wdata >> {off, 3'h0};
      n.hold = ba;
      n.pin_cs = n.cs_hit;
      n.rd = (n.kind != `EMB_KIND_WRITE);
      if (n.bus16 && n.bytesel) begin
        n.hold[0] = !lo;
        n.wr0 = (n.kind == `EMB_KIND_WRITE);
        n.wr1 = hi;
      end else begin
        n.wr0 = (n.kind == `EMB_KIND_WRITE) && lo;
        n.wr1 = (n.kind == `EMB_KIND_WRITE) && hi;
      end
      n.d_oe = (n.kind == `EMB_KIND_WRITE);
      if (!n.bus16) begin
        n.d_out = {8'h00, chunk[7:0]};
      end else if (n.size == `EMB_SIZE_BYTE) begin
        n.d_out = {chunk[7:0], chunk[7:0]};
      end else begin
        n.d_out = chunk[15:0];
      end
    end else begin
      n.pin_cs = 8'h00;
      n.rd = 1'b0;
      n.wr0 = 1'b0;
      n.wr1 = 1'b0;
      n.d_oe = 1'b0;
    end
    n.pin_addr = n.hold;
    for (int k = 0; k < 4; k++) begin
      if (chip_select_count > 3'(k)) begin
        n.pin_addr[23-k] = n.pin_cs[4+k];
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign ext_addr_pins = s.pin_addr;
  assign low_chip_select_lines = ~s.pin_cs[3:0];
  assign read_strobe_n = !s.rd;
  assign lower_write_strobe_n = !s.wr0;
  assign upper_write_strobe_n = !s.wr1;
  assign data_out = s.d_out;
  assign data_oe = s.d_oe;
  assign rsp_done = s.rsp_done;
  assign rsp_to_periph = s.rsp_periph;
  assign rsp_rdata = s.rdata;
  assign busy = (s.st == EMB_ACCESS);
  assign abort_valid = s.abort_pulse;
  assign abort_fetch = s.abort_fetch;
  assign abort_vector = s.abort_vector;
  assign abort_address_register = s.aar;
  assign abort_undefined = s.undef;
  assign abort_misaligned = s.misal;
  assign abort_size = s.asize;
  assign abort_type = s.atype;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  property p_abort_quiet;
    abort_valid |-> low_chip_select_lines == 4'hF && !data_oe &&
      read_strobe_n && lower_write_strobe_n && upper_write_strobe_n;
  endproperty
  a_abort_quiet: assert property (p_abort_quiet)
    else $error("aborted access drove the bus");

  property p_idle_quiet;
    !busy && !$past(busy) |-> $stable(ext_addr_pins[19:0]) && !data_oe;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("idle bus did not hold address or float data");

  property p_abort_addr;
    !busy && sel_valid && sel_hits == 8'h00 |=>
      abort_valid && abort_undefined &&
      abort_address_register == $past(sel_addr);
  endproperty
  a_abort_addr: assert property (p_abort_addr)
    else $error("abort address not captured");

  property p_vector;
    abort_valid |-> abort_vector ==
      (abort_fetch ? `EMB_VEC_PREFETCH : `EMB_VEC_DATA);
  endproperty
  a_vector: assert property (p_vector)
    else $error("abort vector wrong for access type");

  property p_overlap;
    !busy && sel_valid && sel_hits != 8'h00 && !sel_addr[0] &&
      sel_size == `EMB_SIZE_BYTE && !protection_mode_input |=>
      busy && low_chip_select_lines == ~$past(sel_hits[3:0]);
  endproperty
  a_overlap: assert property (p_overlap)
    else $error("matching chip-selects not all asserted");

  property p_single;
    busy && s.beat == s.last_beat && wait_request_n |=> rsp_done && !busy;
  endproperty
  a_single: assert property (p_single)
    else $error("access did not end in one cycle");

  property p_wait;
    busy && !wait_request_n |=> busy && !rsp_done &&
      $stable(ext_addr_pins) && $stable(read_strobe_n);
  endproperty
  a_wait: assert property (p_wait)
    else $error("wait request did not stretch the access");

  property p_misal;
    !busy && sel_valid && sel_size == `EMB_SIZE_WORD &&
      sel_addr[1:0] != 2'h0 |=>
      abort_valid && abort_misaligned && abort_size == `EMB_SIZE_WORD;
  endproperty
  a_misal: assert property (p_misal)
    else $error("misaligned abort status wrong");

  c_read: cover property (busy && !read_strobe_n ##1 rsp_done);
  c_write_wait: cover property (busy && data_oe && !wait_request_n);
  c_abort_fetch: cover property (abort_valid && abort_fetch);
  c_periph: cover property (rsp_done && rsp_to_periph);

endmodule // emb_ctrl

// ===== emb_mem_model.sv
`timescale 1ns/1ps

module emb_mem_model (
  input wire logic core_clk,
  input wire logic [23:0] ext_addr_pins,
  input wire logic [3:0] low_chip_select_lines,
  input wire logic cs_high,
  input wire logic wide,
  input wire logic read_strobe_n,
  input wire logic lower_write_strobe_n,
  input wire logic upper_write_strobe_n,
  input wire logic [15:0] data_out,
  input wire logic [7:0] waits,
  output logic [15:0] data_in,
  output logic wait_request_n
);
  logic [7:0] mem [0:65535];
  logic [15:0] last;
  logic [15:0] a;
  logic sel;
  int cnt;

  assign sel = (low_chip_select_lines != 4'hF) || cs_high;
  assign a = ext_addr_pins[15:0];
  // an undriven bus toggles every cycle so a stale value never matches
  assign data_in = (sel && !read_strobe_n) ?
    {wide ? mem[a | 16'h1] : ~last[15:8],
     wide ? mem[a & 16'hFFFE] : mem[a]} : ~last;
  // stretch only the first cycles of a selected access
  assign wait_request_n = !(sel && cnt < waits);

  initial begin
    last = 16'h0;
    cnt = 0;
    for (int i = 0; i < 65536; i++) begin
      mem[i] = i[7:0] ^ 8'h3C;
    end
  end

  always @(posedge core_clk) begin
    last <= data_in;
    cnt <= sel ? cnt + 1 : 0;
    if (sel && !lower_write_strobe_n) begin
      mem[wide ? (a & 16'hFFFE) : a] <= data_out[7:0];
    end
    if (sel && wide && !upper_write_strobe_n) begin
      mem[a | 16'h1] <= data_out[15:8];
    end
  end
endmodule // emb_mem_model

// ===== tb.sv
`timescale 1ns/1ps

module tb;
  import emb_pkg::*;
  logic core_clk = 0, arst_n = 0;
  logic core_req_valid = 0, core_req_privileged = 1, periph_req_valid = 0;
  logic [31:0] core_req_addr = 0, core_req_wdata = 0;
  logic [31:0] periph_req_addr = 0, periph_req_wdata = 0;
  emb_size_t core_req_size = 0, periph_req_size = 0;
  emb_kind_t core_req_kind = 0;
  logic periph_req_write = 0, protection_mode_input = 0;
  logic [95:0] cs_base = 96'h0;
  logic [15:0] cs_page_size = 16'h0;
  logic [7:0] cs_enable = 8'h13, bus_width_select = 8'h01;
  logic [7:0] byte_access_type = 8'h00, cs_privileged_only = 8'h00;
  logic [2:0] chip_select_count = 3'h0;
  logic core_req_ready, periph_req_ready, rsp_done, rsp_to_periph, busy;
  logic abort_valid, abort_fetch, abort_undefined, abort_misaligned;
  logic [31:0] rsp_rdata, abort_vector, abort_address_register;
  emb_size_t abort_size;
  emb_kind_t abort_type;
  logic [23:0] ext_addr_pins;
  logic [3:0] low_chip_select_lines;
  logic read_strobe_n, lower_write_strobe_n, upper_write_strobe_n;
  logic [15:0] data_out, data_in;
  logic data_oe, wait_request_n, cs_high, wide, act, hi_seen;
  logic [7:0] waits = 8'h00;
  logic [23:0] snap;
  int n_mismatch = 0, compares = 0, cyc;

  always #2.5 core_clk = ~core_clk;
  assign cs_high = (chip_select_count != 3'h0) && ext_addr_pins[23];
  assign wide = !cs_high && !low_chip_select_lines[0];

  emb_ctrl DUT (.*);
  emb_mem_model mem_i (.*);

  // ------------------------------------------------------------
  // shared helpers
  // ------------------------------------------------------------
  always @(negedge core_clk) begin
    if (busy === 1'b1 || read_strobe_n === 1'b0 ||
        lower_write_strobe_n === 1'b0 || low_chip_select_lines !== 4'hF)
      act = 1;
    if (busy === 1'b1 && ext_addr_pins[23] === 1'b1 &&
        low_chip_select_lines === 4'hF)
      hi_seen = 1;
    // last beat's pins, for single-beat mode checks
    if (busy === 1'b1)
      snap = {low_chip_select_lines, upper_write_strobe_n,
              lower_write_strobe_n, read_strobe_n, ext_addr_pins[0],
              data_out};
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic req(input logic periph, input logic [31:0] a,
                     input emb_size_t sz, input emb_kind_t k,
                     input logic [31:0] wd);
    act = 0;
    if (periph) begin
      periph_req_valid = 1;
      periph_req_addr = a;
      periph_req_size = sz;
      periph_req_write = (k == 2'h1);
      periph_req_wdata = wd;
    end else begin
      core_req_valid = 1;
      core_req_addr = a;
      core_req_size = sz;
      core_req_kind = k;
      core_req_wdata = wd;
    end
    for (int n = 0; n < 20; n++) begin
      if ((periph ? periph_req_ready : core_req_ready) === 1'b1) break;
      @(negedge core_clk);
    end
    if ((periph ? periph_req_ready : core_req_ready) !== 1'b1) begin
      n_mismatch++;
      $display("BAD %0t request never taken", $time);
    end
    @(negedge core_clk);
    core_req_valid = 0;
    periph_req_valid = 0;
    cyc = 1;
    for (int n = 0; n < 30; n++) begin
      if (rsp_done === 1'b1 || abort_valid === 1'b1) break;
      @(negedge core_clk);
      cyc++;
    end
    if (rsp_done !== 1'b1 && abort_valid !== 1'b1) begin
      n_mismatch++;
      $display("BAD %0t no response", $time);
    end
  endtask

  task automatic wrap_up;
    if (n_mismatch == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    chk(abort_address_register, 0, "aar");
    chk({abort_undefined, abort_misaligned, abort_size, abort_type}, 0,
        "asr");
    chk({read_strobe_n, lower_write_strobe_n, upper_write_strobe_n,
         low_chip_select_lines, data_oe}, 32'hFE, "idle");
  endtask

  task automatic t_half16;
    req(0, 32'h4000_0006, 2'h1, 2'h0, 0);
    chk(cyc, 2, "half cycles");
    chk(rsp_rdata, 32'h3B3A, "half data");
    chk(ext_addr_pins[15:1], 15'h3, "half addr");
  endtask

  task automatic t_word8;
    req(0, 32'h4010_0004, 2'h2, 2'h1, 32'hA1B2_C3D4);
    chk(cyc, 5, "w8 cycles");
    chk({mem_i.mem[7], mem_i.mem[6], mem_i.mem[5], mem_i.mem[4]},
        32'hA1B2_C3D4, "w8 mem");
    @(negedge core_clk);
    chk({data_oe, read_strobe_n, lower_write_strobe_n}, 3'h3, "float");
    chk(ext_addr_pins[15:0], 16'h7, "addr held");
    req(0, 32'h4010_0004, 2'h2, 2'h0, 0);
    chk(rsp_rdata, 32'hA1B2_C3D4, "r8 data");
  endtask

  task automatic t_abort;
    req(0, 32'h7000_0000, 2'h2, 2'h2, 0);
    chk({abort_valid, abort_fetch}, 2'h3, "fetch ab");
    chk(abort_vector, 32'hC, "fetch vec");
    chk(act, 0, "ab quiet");
    req(1, 32'h7000_0010, 2'h1, 2'h1, 0);
    chk(abort_vector, 32'h10, "data ab");
    chk(abort_address_register, 32'h7000_0010, "aar ow");
    chk({abort_size, abort_type}, 4'h5, "asr");
    chk(abort_undefined, 1, "undef");
  endtask

  task automatic t_wait;
    waits = 8'h03;
    req(0, 32'h4000_0002, 2'h0, 2'h0, 0);
    waits = 8'h00;
    chk(cyc, 5, "wait cycles");
    chk(rsp_rdata, 32'h3E, "wait data");
  endtask

  task automatic t_cs4;
    chip_select_count = 3'h1;
    hi_seen = 0;
    req(0, 32'h5000_0002, 2'h0, 2'h0, 0);
    chk(hi_seen, 1, "cs4 pin");
    chk(rsp_rdata, 32'h3E, "cs4 data");
    chip_select_count = 3'h0;
  endtask

  task automatic t_periph;
    req(1, 32'h4000_0008, 2'h1, 2'h0, 0);
    chk(rsp_to_periph, 1, "periph dst");
    chk(rsp_rdata, 32'h3534, "periph data");
  endtask

  task automatic t_modes;
    cs_base[12+:12] = 12'h400;
    req(0, 32'h4000_0002, 2'h0, 2'h0, 0);
    chk(snap[23:20], 4'hC, "overlap cs");
    chk(rsp_rdata, 32'h3E, "overlap data");
    cs_base[12+:12] = 12'h401;
    byte_access_type = 8'h01;
    req(0, 32'h4000_0005, 2'h0, 2'h1, 32'h5A);
    chk(snap[19:0], 20'h35A5A, "bytesel pins");
    chk(mem_i.mem[5], 8'h5A, "bytesel upper");
    byte_access_type = 8'h00;
    req(0, 32'h4000_000A, 2'h1, 2'h1, 32'hBEEF);
    chk(snap[19:0], 20'h2BEEF, "bytewr pins");
    chk({mem_i.mem[11], mem_i.mem[10]}, 16'hBEEF, "bytewr mem");
    req(0, 32'h4000_0002, 2'h2, 2'h0, 0);
    chk({abort_valid, abort_misaligned, abort_undefined}, 3'h6,
        "misal");
    protection_mode_input = 1;
    cs_privileged_only = 8'h01;
    core_req_privileged = 0;
    req(0, 32'h4000_0000, 2'h0, 2'h0, 0);
    chk({abort_valid, act, abort_undefined, abort_misaligned}, 4'h8,
        "priv ab");
    core_req_privileged = 1;
    req(0, 32'h4000_0000, 2'h0, 2'h0, 0);
    chk(rsp_done, 1, "priv ok");
    protection_mode_input = 0;
    cs_privileged_only = 8'h00;
    cs_page_size[9:8] = 2'h1;
    req(0, 32'h5030_0002, 2'h0, 2'h0, 0);
    chk({rsp_done, abort_valid}, 2'h2, "page wrap");
  endtask

  initial begin
    cs_base[0+:12] = 12'h400;
    cs_base[12+:12] = 12'h401;
    cs_base[48+:12] = 12'h500;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    t_reset();
    arst_n = 1;
    @(negedge core_clk);
    t_half16();
    t_word8();
    t_abort();
    t_wait();
    t_cs4();
    t_periph();
    t_modes();
    wrap_up();
  end

  // the whole run needs under a thousand cycles
  initial begin
    #20000;
    n_mismatch++;
    wrap_up();
  end
endmodule // tb
